// >>> core/error_exception_classifier.sv
`timescale 1ns/10ps

module error_exception_classifier (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Detected error report
  input  wire logic       err_valid,
  input  wire logic       err_correctable,
  input  wire logic       err_deferrable,
  input  wire logic       err_is_write,
  input  wire logic       err_speculative,
  input  wire logic       err_committed_data,
  input  wire logic       err_committed_fetch,
  input  wire logic       err_committed_walk,
  input  wire logic       err_undetected_use,
  input  wire logic       err_corrupt_store,
  input  wire logic       err_corrupt_sysreg,
  input  wire logic       err_spurious_signal,
  input  wire logic       err_dirty_discard,
  input  wire logic       err_gpr_only,
  input  wire logic       err_after_sync,
  input  wire logic       err_no_other_path,
  input  wire logic       err_imprecise,
  input  wire logic       err_needs_repair,
  input  wire logic       err_maybe_propagated,
  // Configuration straps
  input  wire logic [1:0] cfg_write_resp,
  input  wire logic       cfg_abort_sync,
  input  wire logic       cfg_exc_on_corrected,
  input  wire logic [2:0] cfg_min_sev,
  input  wire logic       cfg_fail_mode,
  // Node system register port
  input  wire logic [3:0] node_err,
  input  wire logic       node_sel_wr,
  input  wire logic [1:0] node_sel_wdata,
  output      logic [1:0] node_sel,
  output      logic       node_pending,
  output      logic [1:0] node_first,
  // Responses
  output      logic       corrected_pulse,
  output      logic       deferred_pulse,
  output      logic       poison_write,
  output      logic       recovery_irq,
  output      logic       fault_irq,
  output      logic       log_valid,
  output      logic [2:0] log_sev,
  output      logic       exc_raise,
  output      logic [2:0] exc_sev,
  output      logic       exc_sync,
  output      logic       failure_mode
);

  // ************************************************************
  // Classification
  // ************************************************************
  wire       fixable;
  wire       consumed;
  wire       propagated;
  wire       wr_abort;
  wire       uncorr;
  wire       raise;
  wire       async_del;
  wire [2:0] grade;
  wire       any_node;
  wire [1:0] first_idx;

  assign fixable = err_valid & (err_correctable | err_deferrable);

  assign consumed = err_committed_data | err_committed_fetch |
                    err_committed_walk;

  assign propagated = err_undetected_use | err_corrupt_store |
                      err_corrupt_sysreg | err_spurious_signal |
                      err_dirty_discard;

  assign wr_abort = ~err_is_write |
                    (cfg_write_resp == err_cls_pkg::WR_RESP_ABORT);

  assign uncorr = err_valid & ~fixable;

  assign raise = (uncorr & wr_abort & ~(cfg_fail_mode & consumed)) |
                 (fixable & cfg_exc_on_corrected);

  assign async_del = (err_speculative & ~consumed) | ~cfg_abort_sync;

  err_severity_grade u_grade (
    .propagated         (propagated),
    .maybe_propagated   (err_maybe_propagated),
    .contained_gpr_only (err_gpr_only),
    .after_sync_point   (err_after_sync),
    .no_other_path      (err_no_other_path),
    .consumed           (consumed),
    .imprecise          (err_imprecise),
    .needs_sw_repair    (err_needs_repair),
    .min_sev            (cfg_min_sev),
    .sev                (grade)
  );

  err_node_select u_nodes (
    .node_err (node_err),
    .any_err  (any_node),
    .node_idx (first_idx)
  );

  // ************************************************************
  // Registered outputs
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      corrected_pulse <= 1'b0;
      deferred_pulse  <= 1'b0;
      poison_write    <= 1'b0;
      recovery_irq    <= 1'b0;
      fault_irq       <= 1'b0;
      log_valid       <= 1'b0;
      log_sev         <= err_cls_pkg::MIN_SEV_RESET;
      exc_raise       <= 1'b0;
      exc_sev         <= err_cls_pkg::MIN_SEV_RESET;
      exc_sync        <= err_cls_pkg::ABORT_SYNC_RESET;
      failure_mode    <= 1'b0;
    end else begin
      corrected_pulse <= err_valid & err_correctable;
      deferred_pulse  <= err_valid & ~err_correctable & err_deferrable;
      fault_irq       <= fixable;
      log_valid       <= err_valid;
      log_sev         <= err_valid ? grade : err_cls_pkg::MIN_SEV_RESET;
      // Poison or recovery interrupt for writes
      poison_write    <= uncorr & err_is_write &
                         (cfg_write_resp == err_cls_pkg::WR_RESP_POISON);
      recovery_irq    <= uncorr & err_is_write &
                         (cfg_write_resp == err_cls_pkg::WR_RESP_RECINT);
      // Class and sync flag with the raise
      exc_raise       <= raise;
      exc_sev         <= raise ? grade : err_cls_pkg::MIN_SEV_RESET;
      exc_sync        <= raise & ~async_del;
      // Failure mode is sticky until reset
      if (uncorr & consumed & cfg_fail_mode) begin
        failure_mode <= 1'b1;
      end
    end
  end

  // Node selection register and sticky pending flag
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      node_sel     <= err_cls_pkg::NODE_IDX_RESET;
      node_pending <= 1'b0;
      node_first   <= err_cls_pkg::NODE_IDX_RESET;
    end else begin
      if (node_sel_wr) begin
        node_sel <= node_sel_wdata;
      end
      // Set wins over clear
      if (any_node & ~node_pending) begin
        node_pending <= 1'b1;
        node_first   <= first_idx;
      end else if (node_sel_wr & ~any_node) begin
        node_pending <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  a_uc_on_prop: assert property (
    @(posedge sys_clk) disable iff (rst)
    (err_valid & ~fixable & err_maybe_propagated & raise) |=>
      (exc_sev == err_cls_pkg::uncontainable_class))
    else $error("propagated error not uncontainable");

  a_abort_raises: assert property (
    @(posedge sys_clk) disable iff (rst)
    (uncorr & ~err_is_write & ~(cfg_fail_mode & consumed)) |=> exc_raise)
    else $error("uncorrected abort raised no exception");

  a_fixed_irq: assert property (
    @(posedge sys_clk) disable iff (rst)
    fixable |=> (fault_irq & log_valid))
    else $error("corrected error gave no fault interrupt");

  a_spec_async: assert property (
    @(posedge sys_clk) disable iff (rst)
    (raise & err_speculative & ~consumed) |=> (exc_raise & ~exc_sync))
    else $error("speculative abort delivered synchronously");

  a_sync_choice: assert property (
    @(posedge sys_clk) disable iff (rst)
    (raise & ~err_speculative & cfg_abort_sync) |=> exc_sync)
    else $error("sync configuration ignored");

  a_consumed_act: assert property (
    @(posedge sys_clk) disable iff (rst)
    (uncorr & consumed & ~err_is_write) |=> (exc_raise | failure_mode))
    else $error("consumed error had no action");

  a_no_corr_exc: assert property (
    @(posedge sys_clk) disable iff (rst)
    (fixable & ~cfg_exc_on_corrected) |=> ~exc_raise)
    else $error("fixable error escalated");

  a_sev_floor: assert property (
    @(posedge sys_clk) disable iff (rst)
    exc_raise |-> (exc_sev >= $past(cfg_min_sev)))
    else $error("severity below floor");

  a_restart_cls: assert property (
    @(posedge sys_clk) disable iff (rst)
    (raise & ~propagated & ~err_maybe_propagated & ~consumed &
     ~err_imprecise & ~err_needs_repair & (cfg_min_sev == 3'h0)) |=>
      (exc_sev == err_cls_pkg::restartable_class))
    else $error("restartable error misclassed");

  a_write_resp: assert property (
    @(posedge sys_clk) disable iff (rst)
    (uncorr & err_is_write &
     (cfg_write_resp == err_cls_pkg::WR_RESP_POISON)) |=>
      (poison_write & ~recovery_irq))
    else $error("write poison response missing");

  a_corr_pulse: assert property (
    @(posedge sys_clk) disable iff (rst)
    (err_valid & err_correctable) |=> (corrected_pulse & ~deferred_pulse))
    else $error("corrected error gave no correction pulse");

  a_defer_pulse: assert property (
    @(posedge sys_clk) disable iff (rst)
    (err_valid & ~err_correctable & err_deferrable) |=>
      (deferred_pulse & ~corrected_pulse))
    else $error("deferrable error gave no deferral pulse");

  a_fixed_quiet: assert property (
    @(posedge sys_clk) disable iff (rst)
    fixable |=> (~poison_write & ~recovery_irq))
    else $error("fixable error gave an uncorrected response");

  a_log_idle: assert property (
    @(posedge sys_clk) disable iff (rst)
    ~err_valid |=> (~log_valid & (log_sev == err_cls_pkg::MIN_SEV_RESET)))
    else $error("log written without an error report");

  a_exc_on_fixed: assert property (
    @(posedge sys_clk) disable iff (rst)
    (fixable & cfg_exc_on_corrected) |=> exc_raise)
    else $error("optional exception for fixed error missing");

  a_write_abort: assert property (
    @(posedge sys_clk) disable iff (rst)
    (uncorr & err_is_write & ~(cfg_fail_mode & consumed) &
     (cfg_write_resp == err_cls_pkg::WR_RESP_ABORT)) |=>
      (exc_raise & ~poison_write & ~recovery_irq))
    else $error("write abort response missing");

  a_write_recint: assert property (
    @(posedge sys_clk) disable iff (rst)
    (uncorr & err_is_write &
     (cfg_write_resp == err_cls_pkg::WR_RESP_RECINT)) |=>
      (recovery_irq & ~poison_write & ~exc_raise))
    else $error("write recovery interrupt missing");

  a_async_cfg: assert property (
    @(posedge sys_clk) disable iff (rst)
    (raise & ~cfg_abort_sync) |=> (exc_raise & ~exc_sync))
    else $error("async configuration ignored");

  a_fail_entry: assert property (
    @(posedge sys_clk) disable iff (rst)
    (uncorr & consumed & cfg_fail_mode) |=> failure_mode)
    else $error("failure mode not entered");

  a_fail_sticky: assert property (
    @(posedge sys_clk) disable iff (rst)
    failure_mode |=> failure_mode)
    else $error("failure mode left without reset");

  a_prop_uc: assert property (
    @(posedge sys_clk) disable iff (rst)
    (raise & propagated &
     ~(err_gpr_only & err_after_sync & err_no_other_path)) |=>
      (exc_sev == err_cls_pkg::uncontainable_class))
    else $error("propagation event not uncontainable");

  a_contained: assert property (
    @(posedge sys_clk) disable iff (rst)
    (raise & propagated & err_gpr_only & err_after_sync &
     err_no_other_path & ~err_maybe_propagated &
     (cfg_min_sev < 3'h4)) |=>
      (exc_sev != err_cls_pkg::uncontainable_class))
    else $error("contained error reported uncontainable");

  a_unrec_cls: assert property (
    @(posedge sys_clk) disable iff (rst)
    (raise & ~propagated & ~err_maybe_propagated &
     (consumed | err_imprecise) & (cfg_min_sev <= 3'h3)) |=>
      (exc_sev == err_cls_pkg::unrecoverable_class))
    else $error("unrecoverable error misclassed");

  a_recov_cls: assert property (
    @(posedge sys_clk) disable iff (rst)
    (raise & ~propagated & ~err_maybe_propagated & ~consumed &
     ~err_imprecise & err_needs_repair & (cfg_min_sev <= 3'h2)) |=>
      (exc_sev == err_cls_pkg::recoverable_class))
    else $error("recoverable error misclassed");

  a_exc_idle: assert property (
    @(posedge sys_clk) disable iff (rst)
    ~exc_raise |-> ((exc_sev == err_cls_pkg::MIN_SEV_RESET) & ~exc_sync))
    else $error("class shown without exception");

  a_node_set: assert property (
    @(posedge sys_clk) disable iff (rst)
    any_node |=> node_pending)
    else $error("node error not pending");

  a_node_first: assert property (
    @(posedge sys_clk) disable iff (rst)
    (any_node & ~node_pending) |=> (node_first == $past(first_idx)))
    else $error("first node index not captured");

  a_node_clear: assert property (
    @(posedge sys_clk) disable iff (rst)
    (node_sel_wr & ~any_node) |=> ~node_pending)
    else $error("node pending not cleared");

  a_node_write: assert property (
    @(posedge sys_clk) disable iff (rst)
    node_sel_wr |=> (node_sel == $past(node_sel_wdata)))
    else $error("node select write lost");

endmodule // error_exception_classifier

// >>> core/err_cls_pkg.sv
package err_cls_pkg;

  // Severity classes, most severe has the largest code
  typedef enum logic [2:0] {
    SEV_NONE          = 3'b000,
    restartable_class = 3'b001,
    recoverable_class = 3'b010,
    unrecoverable_class = 3'b011,
    uncontainable_class = 3'b100
  } severity_e;

  // Write error response choices
  localparam logic [1:0] WR_RESP_POISON = 2'h0;
  localparam logic [1:0] WR_RESP_ABORT  = 2'h1;
  localparam logic [1:0] WR_RESP_RECINT = 2'h2;

  // Reset values
  localparam logic [1:0] WR_RESP_RESET    = 2'h0;
  localparam logic       ABORT_SYNC_RESET = 1'b0;
  localparam logic [2:0] MIN_SEV_RESET    = 3'h0;

  // Node count and index width
  localparam int NODE_COUNT = 4;
  localparam int NODE_IDX_W = 2;
  localparam logic [NODE_IDX_W-1:0] NODE_IDX_RESET = 2'h0;

  // Escalate a class to a minimum severity floor
  function automatic logic [2:0] sev_max(input logic [2:0] a,
                                         input logic [2:0] b);
    sev_max = (a > b) ? a : b;
  endfunction

endpackage

// >>> core/err_severity_grade.sv
`timescale 1ns/10ps
module err_severity_grade (
  input  wire logic       propagated,
  input  wire logic       maybe_propagated,
  input  wire logic       contained_gpr_only,
  input  wire logic       after_sync_point,
  input  wire logic       no_other_path,
  input  wire logic       consumed,
  input  wire logic       imprecise,
  input  wire logic       needs_sw_repair,
  input  wire logic [2:0] min_sev,
  output      logic [2:0] sev
);

  wire contained_exc;
  wire silent;
  wire [2:0] base_sev;

  assign contained_exc = contained_gpr_only & after_sync_point & no_other_path;
  assign silent = (propagated & ~contained_exc) | maybe_propagated;

  assign base_sev =
    silent                 ? err_cls_pkg::uncontainable_class :
    (consumed | imprecise) ? err_cls_pkg::unrecoverable_class :
    needs_sw_repair        ? err_cls_pkg::recoverable_class :
                             err_cls_pkg::restartable_class;

  assign sev = err_cls_pkg::sev_max(base_sev, min_sev);

endmodule // err_severity_grade

// >>> core/err_node_select.sv
`timescale 1ns/10ps
module err_node_select (
  input  wire logic [3:0] node_err,
  output      logic       any_err,
  output      logic [1:0] node_idx
);

  // Lowest numbered reporting node wins
  assign any_err  = |node_err;
  assign node_idx = node_err[0] ? 2'h0 :
                    node_err[1] ? 2'h1 :
                    node_err[2] ? 2'h2 :
                    node_err[3] ? 2'h3 : 2'h0;

endmodule // err_node_select

// >>> test/error_source_model.sv
`timescale 1ns/10ps
module error_source_model (
  input  wire logic        sys_clk,
  input  wire logic        go,
  input  wire logic [17:0] rep,
  output      logic        err_valid,
  output      logic [17:0] eb
);
  // ****************
  // Report lines
  // ****************
  logic [17:0] pat = 18'h15555;

  // Idle qualifiers change every cycle
  always_ff @(posedge sys_clk) begin
    pat <= ~pat;
  end

  assign err_valid = go;
  assign eb        = go ? rep : pat;
endmodule // error_source_model

// >>> test/tb_error_exception_classifier.sv
`timescale 1ns/10ps
module tb_error_exception_classifier;
  // ****************
  // Harness
  // ****************
  localparam logic [17:0] WR = 18'h4, SPEC = 18'h8, CDATA = 18'h10;
  localparam logic [17:0] COR = 18'h1, DEF = 18'h2, IMPR = 18'h8000;
  localparam logic [17:0] REPAIR = 18'h10000, MAYBE = 18'h20000;
  localparam logic [2:0] RS = err_cls_pkg::restartable_class;
  localparam logic [2:0] RC = err_cls_pkg::recoverable_class;
  localparam logic [2:0] UU = err_cls_pkg::unrecoverable_class;
  localparam logic [2:0] UC = err_cls_pkg::uncontainable_class;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        go = 1'b0;
  logic [17:0] rep = 18'h0;
  logic [1:0]  cfg_write_resp = 2'h3;
  logic        cfg_abort_sync = 1'b1;
  logic        cfg_exc_on_corrected = 1'b0;
  logic [2:0]  cfg_min_sev = 3'h0;
  logic        cfg_fail_mode = 1'b0;
  logic [3:0]  node_err = 4'h0;
  logic        node_sel_wr = 1'b0;
  logic [1:0]  node_sel_wdata = 2'h0;
  logic        err_valid, node_pending, corrected_pulse, deferred_pulse;
  logic        poison_write, recovery_irq, fault_irq, log_valid;
  logic        exc_raise, exc_sync, failure_mode;
  logic [17:0] eb;
  logic [1:0]  node_sel, node_first;
  logic [2:0]  log_sev, exc_sev;
  int          err_count = 0;
  int          checked = 0;

  always #2.5 sys_clk = ~sys_clk;

  error_source_model src (.sys_clk(sys_clk), .go(go), .rep(rep),
    .err_valid(err_valid), .eb(eb));

  error_exception_classifier dut (
    .sys_clk(sys_clk),                 .rst(rst),
    .err_valid(err_valid),             .cfg_write_resp(cfg_write_resp),
    .cfg_abort_sync(cfg_abort_sync),
    .cfg_exc_on_corrected(cfg_exc_on_corrected),
    .cfg_min_sev(cfg_min_sev),         .cfg_fail_mode(cfg_fail_mode),
    .node_err(node_err),               .node_sel_wr(node_sel_wr),
    .node_sel_wdata(node_sel_wdata),   .node_sel(node_sel),
    .node_pending(node_pending),       .node_first(node_first),
    .corrected_pulse(corrected_pulse), .deferred_pulse(deferred_pulse),
    .poison_write(poison_write),       .recovery_irq(recovery_irq),
    .fault_irq(fault_irq),             .log_valid(log_valid),
    .log_sev(log_sev),                 .exc_raise(exc_raise),
    .exc_sev(exc_sev),                 .exc_sync(exc_sync),
    .failure_mode(failure_mode),
    .err_correctable(eb[0]),      .err_deferrable(eb[1]),
    .err_is_write(eb[2]),         .err_speculative(eb[3]),
    .err_committed_data(eb[4]),   .err_committed_fetch(eb[5]),
    .err_committed_walk(eb[6]),   .err_undetected_use(eb[7]),
    .err_corrupt_store(eb[8]),    .err_corrupt_sysreg(eb[9]),
    .err_spurious_signal(eb[10]), .err_dirty_discard(eb[11]),
    .err_gpr_only(eb[12]),        .err_after_sync(eb[13]),
    .err_no_other_path(eb[14]),   .err_imprecise(eb[15]),
    .err_needs_repair(eb[16]),    .err_maybe_propagated(eb[17]));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic send(input logic [17:0] r);
    @(posedge sys_clk);
    go  <= 1'b1;
    rep <= r;
    @(posedge sys_clk) go <= 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic exc(input logic [17:0] r, input logic [2:0] s,
                     input logic y);
    send(r);
    chk({exc_raise, exc_sev, exc_sync}, {1'b1, s, y});
    chk({log_valid, log_sev}, {1'b1, s});
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic t_fix();
    send(COR);
    chk({corrected_pulse, deferred_pulse, fault_irq, log_valid, exc_raise,
         exc_sev}, 8'hB0);
    send(DEF);
    chk({corrected_pulse, deferred_pulse, fault_irq, log_valid, exc_raise},
        5'h0E);
    @(posedge sys_clk) cfg_exc_on_corrected <= 1'b1;
    send(COR);
    chk({corrected_pulse, exc_raise}, 2'h3);
    @(posedge sys_clk) cfg_exc_on_corrected <= 1'b0;
  endtask

  task automatic t_class();
    exc(18'h0, RS, 1'b1);
    exc(REPAIR, RC, 1'b1);
    exc(IMPR, UU, 1'b1);
    for (int i = 0; i < 3; i++) begin
      exc(CDATA << i, UU, 1'b1);
    end
    for (int i = 0; i < 5; i++) begin
      exc(18'h80 << i, UC, 1'b1);
    end
    exc(MAYBE, UC, 1'b1);
    exc(18'h7090, UU, 1'b1);
    exc(18'h3090, UC, 1'b1);
    exc(SPEC, RS, 1'b0);
    @(posedge sys_clk) cfg_abort_sync <= 1'b0;
    exc(18'h0, RS, 1'b0);
    @(posedge sys_clk) cfg_min_sev <= 3'h3;
    exc(18'h0, UU, 1'b0);
    exc(MAYBE, UC, 1'b0);
    @(posedge sys_clk) cfg_min_sev <= 3'h0;
  endtask

  task automatic t_write();
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk) cfg_write_resp <= 2'(k);
      send(WR);
      chk({poison_write, exc_raise, recovery_irq}, 3'h4 >> k);
    end
  endtask

  task automatic t_b2b();
    @(posedge sys_clk);
    go  <= 1'b1;
    rep <= MAYBE;
    @(posedge sys_clk) rep <= REPAIR;
    @(negedge sys_clk);
    chk(exc_sev, UC);
    @(posedge sys_clk) go <= 1'b0;
    @(negedge sys_clk);
    chk(exc_sev, RC);
  endtask

  task automatic t_node();
    @(posedge sys_clk) node_err <= 4'h4;
    @(posedge sys_clk) node_err <= 4'h0;
    @(negedge sys_clk);
    chk({node_pending, node_first}, 3'h6);
    @(negedge sys_clk);
    chk({node_pending, log_valid, log_sev}, 5'h10);
    @(posedge sys_clk);
    node_sel_wr    <= 1'b1;
    node_sel_wdata <= 2'h3;
    @(posedge sys_clk) node_sel_wr <= 1'b0;
    @(negedge sys_clk);
    chk({node_sel, node_pending}, 3'h6);
    @(posedge sys_clk);
    node_err    <= 4'h2;
    node_sel_wr <= 1'b1;
    @(posedge sys_clk);
    node_err    <= 4'h0;
    node_sel_wr <= 1'b0;
    @(negedge sys_clk);
    chk({node_pending, node_first}, 3'h5);
  endtask

  task automatic t_fail();
    @(posedge sys_clk) cfg_fail_mode <= 1'b1;
    send(CDATA);
    chk({exc_raise, failure_mode}, 2'h1);
    send(COR);
    chk(failure_mode, 1'b1);
    send(18'h0);
    chk({exc_raise, failure_mode}, 2'h3);
    @(posedge sys_clk) rst <= 1'b1;
    @(posedge sys_clk) cfg_fail_mode <= 1'b0;
    @(posedge sys_clk) rst <= 1'b0;
    @(negedge sys_clk);
    chk({failure_mode, node_pending}, 2'h0);
    exc(18'h0, RS, 1'b0);
  endtask

  task automatic print_verdict();
    if (err_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #20000;
    err_count++;
    print_verdict();
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    t_fix();
    t_class();
    t_write();
    t_b2b();
    t_node();
    t_fail();
    print_verdict();
  end
endmodule // tb_error_exception_classifier
